/* File: include/aof_regs.svh */
`ifndef AOF_REGS_SVH
`define AOF_REGS_SVH
// converter data width
`define AOF_DATA_W 14
// pipeline latency in strobe periods
`define AOF_LATENCY 5
// strobe cycles the stabilizer needs to relock
`define AOF_RELOCK_CYCLES 100
// idle system clocks after which the strobe counts as stopped
`define AOF_STOP_CLKS 64
// format pin codes (level 0..3)
`define AOF_MODE_GND 2'h0
`define AOF_MODE_THIRD 2'h1
`define AOF_MODE_TWO_THIRDS 2'h2
`define AOF_MODE_VDD 2'h3
// interrupt status bit positions
`define AOF_IRQ_OVR 0
`define AOF_IRQ_LOCK 1
`define AOF_IRQ_W 2
`endif

/* File: include/aof_pkg.sv */
package aof_pkg;
  typedef enum logic [1:0] {
    AOF_FMT_OFFSET,
    AOF_FMT_TWOS
  } aof_fmt_t;
  typedef enum logic [1:0] {
    AOF_S_IDLE,
    AOF_S_LOCKING,
    AOF_S_LOCKED
  } aof_lock_t;
endpackage

/* File: rtl/aof_formatter.sv */
`timescale 1ns/1ps
`include "aof_regs.svh"
module aof_formatter
  import aof_pkg::*;
#(
  parameter int DATA_W = `AOF_DATA_W,
  parameter int LATENCY = `AOF_LATENCY,
  parameter int RELOCK = `AOF_RELOCK_CYCLES,
  parameter int STOP_CLKS = `AOF_STOP_CLKS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample_strobe_in,
  input wire logic [DATA_W-1:0] raw_result,
  input wire logic raw_over_range,
  input wire logic [1:0] format_mode,
  input wire logic scramble_enable,
  input wire logic input_range_select,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [DATA_W-1:0] data_out,
  output logic overflow_flag,
  output logic sample_clock_out_true,
  output logic sample_clock_out_inverted,
  output logic gain_narrow,
  output logic stabilizer_on,
  output logic output_valid,
  output logic irq
);
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_MASK = 8'h04;
  localparam logic [7:0] ADDR_STATE = 8'h08;

  // two-flop synchronisers for the strobe and the mode, range and scramble pins
  logic [4:0] sync1, sync2;
  logic [4:0] next_sync1;
  always_comb begin
    next_sync1 = {scramble_enable, input_range_select, format_mode, sample_strobe_in};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= next_sync1;
      sync2 <= sync1;
    end
  end
  logic strobe_s, range_s, scr_s;
  logic [1:0] mode_s;
  assign strobe_s = sync2[0];
  assign mode_s = sync2[2:1];
  assign range_s = sync2[3];
  assign scr_s = sync2[4];

  // mode decode: format and stabilizer from the four-level pin
  aof_fmt_t fmt;
  logic stab;
  always_comb begin
    fmt = (mode_s[1]) ? AOF_FMT_TWOS : AOF_FMT_OFFSET;
    stab = (mode_s == `AOF_MODE_THIRD) || (mode_s == `AOF_MODE_TWO_THIRDS);
  end

  // strobe edge detection and half-period measurement
  logic strobe_d, rise, fall;
  logic [15:0] per_cnt, half_len, hi_cnt, idle_cnt;
  logic [15:0] next_per_cnt, next_half_len, next_hi_cnt, next_idle_cnt;
  logic int_clk, next_int_clk, next_strobe_d;
  assign rise = strobe_s & ~strobe_d;
  assign fall = ~strobe_s & strobe_d;
  always_comb begin
    next_strobe_d = strobe_s;
    next_per_cnt = rise ? 16'h0001 : per_cnt + 16'h0001;
    next_half_len = rise ? {1'b0, per_cnt[15:1]} : half_len;
    next_hi_cnt = rise ? 16'h0001 : hi_cnt + 16'h0001;
    next_idle_cnt = (rise || fall) ? 16'h0000 :
      ((idle_cnt == 16'(STOP_CLKS)) ? idle_cnt : idle_cnt + 16'h0001);
    next_int_clk = int_clk;
    if (rise) begin
      next_int_clk = 1'b1;
    end else if (stab) begin
      // external falling edge ignored; rebuilt at half the last period
      if (hi_cnt >= half_len) begin
        next_int_clk = 1'b0;
      end
    end else if (fall) begin
      next_int_clk = 1'b0;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d <= 1'b0;
      per_cnt <= 16'h0000;
      half_len <= 16'h0001;
      hi_cnt <= 16'h0000;
      idle_cnt <= 16'h0000;
      int_clk <= 1'b0;
    end else begin
      strobe_d <= next_strobe_d;
      per_cnt <= next_per_cnt;
      half_len <= next_half_len;
      hi_cnt <= next_hi_cnt;
      idle_cnt <= next_idle_cnt;
      int_clk <= next_int_clk;
    end
  end
  logic stopped;
  assign stopped = (idle_cnt == 16'(STOP_CLKS));

  // relock tracker: stabilizer needs a run of strobes after a stop
  aof_lock_t lock_st, next_lock_st;
  logic [7:0] lock_cnt, next_lock_cnt;
  always_comb begin
    next_lock_st = lock_st;
    next_lock_cnt = lock_cnt;
    case (lock_st)
      AOF_S_IDLE: begin
        next_lock_cnt = 8'h00;
        if (rise) begin
          next_lock_st = AOF_S_LOCKING;
        end
      end
      AOF_S_LOCKING: begin
        if (stopped) begin
          next_lock_st = AOF_S_IDLE;
        end else if (!stab) begin
          next_lock_st = AOF_S_LOCKED;
        end else if (rise) begin
          next_lock_cnt = lock_cnt + 8'h01;
          if (lock_cnt == 8'(RELOCK - 1)) begin
            next_lock_st = AOF_S_LOCKED;
          end
        end
      end
      AOF_S_LOCKED: begin
        if (stopped) begin
          next_lock_st = AOF_S_IDLE;
        end
      end
      default: next_lock_st = AOF_S_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_st <= AOF_S_IDLE;
      lock_cnt <= 8'h00;
    end else begin
      lock_st <= next_lock_st;
      lock_cnt <= next_lock_cnt;
    end
  end

  // sample pipeline: one stage per strobe rising edge, fixed latency
  logic [DATA_W:0] pipe [LATENCY];
  logic [DATA_W:0] next_pipe [LATENCY];
  always_comb begin
    for (int i = 0; i < LATENCY; i++) begin
      next_pipe[i] = pipe[i];
    end
    if (rise) begin
      next_pipe[0] = {raw_over_range, raw_result};
      for (int i = 1; i < LATENCY; i++) begin
        next_pipe[i] = pipe[i-1];
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe[i] <= '0;
      end
    end else begin
      for (int i = 0; i < LATENCY; i++) begin
        pipe[i] <= next_pipe[i];
      end
    end
  end

  // output formatting: msb flip first, then scramble
  logic [DATA_W-1:0] fmt_word, scr_word;
  always_comb begin
    fmt_word = pipe[LATENCY-1][DATA_W-1:0];
    if (fmt == AOF_FMT_TWOS) begin
      fmt_word[DATA_W-1] = ~fmt_word[DATA_W-1];
    end
    scr_word = fmt_word;
    if (scr_s) begin
      for (int i = 1; i < DATA_W; i++) begin
        scr_word[i] = fmt_word[i] ^ fmt_word[0];
      end
    end
  end

  // output registers; data changes on strobe rise, with true clock falling
  logic [DATA_W-1:0] next_data_out;
  logic next_of, next_ckt, next_valid;
  always_comb begin
    next_data_out = rise ? scr_word : data_out;
    next_of = rise ? pipe[LATENCY-1][DATA_W] : overflow_flag;
    next_ckt = rise ? 1'b0 : ~int_clk;
    next_valid = (lock_st == AOF_S_LOCKED);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_out <= '0;
      overflow_flag <= 1'b0;
      sample_clock_out_true <= 1'b0;
      sample_clock_out_inverted <= 1'b1;
      gain_narrow <= 1'b0;
      stabilizer_on <= 1'b0;
      output_valid <= 1'b0;
    end else begin
      data_out <= next_data_out;
      overflow_flag <= next_of;
      sample_clock_out_true <= next_ckt;
      sample_clock_out_inverted <= ~next_ckt;
      gain_narrow <= range_s;
      stabilizer_on <= stab;
      output_valid <= next_valid;
    end
  end

  // interrupt status (set wins over clear), mask and register reads
  logic [`AOF_IRQ_W-1:0] status, mask, next_status, next_mask, events;
  logic [31:0] next_rdata;
  logic next_irq;
  always_comb begin
    events = '0;
    events[`AOF_IRQ_OVR] = rise & pipe[LATENCY-1][DATA_W];
    events[`AOF_IRQ_LOCK] = (lock_st == AOF_S_LOCKED) && (next_lock_st == AOF_S_IDLE);
    next_status = status;
    next_mask = mask;
    if (reg_write && reg_addr == ADDR_STATUS) begin
      next_status = status & ~reg_wdata[`AOF_IRQ_W-1:0];
    end
    if (reg_write && reg_addr == ADDR_MASK) begin
      next_mask = reg_wdata[`AOF_IRQ_W-1:0];
    end
    next_status = next_status | events;
    next_irq = |(next_status & next_mask);
    next_rdata = 32'h0000_0000;
    if (reg_read) begin
      case (reg_addr)
        ADDR_STATUS: next_rdata = {30'h0, status};
        ADDR_MASK: next_rdata = {30'h0, mask};
        ADDR_STATE: next_rdata = {26'h0, lock_st, range_s, stab, mode_s};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      mask <= '0;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      status <= next_status;
      mask <= next_mask;
      reg_rdata <= next_rdata;
      irq <= next_irq;
    end
  end

  // checks
  property p_clk_pair;
    @(posedge clk) disable iff (!rst_n)
    sample_clock_out_inverted == ~sample_clock_out_true;
  endproperty
  a_clk_pair: assert property (p_clk_pair) else $error("output clocks not complementary");
  property p_data_with_fall;
    @(posedge clk) disable iff (!rst_n)
    rise |=> !sample_clock_out_true;
  endproperty
  a_data_with_fall: assert property (p_data_with_fall) else $error("clock not low at update");
  property p_lsb_kept;
    @(posedge clk) disable iff (!rst_n)
    rise |=> data_out[0] == $past(fmt_word[0]);
  endproperty
  a_lsb_kept: assert property (p_lsb_kept) else $error("lsb altered");
  property p_scramble;
    @(posedge clk) disable iff (!rst_n)
    (rise && scr_s) |=> data_out[DATA_W-1] == ($past(fmt_word[DATA_W-1]) ^ $past(fmt_word[0]));
  endproperty
  a_scramble: assert property (p_scramble) else $error("msb not scrambled");
  property p_plain;
    @(posedge clk) disable iff (!rst_n)
    (rise && !scr_s) |=> data_out == $past(fmt_word);
  endproperty
  a_plain: assert property (p_plain) else $error("data changed without scramble");
  property p_twos;
    @(posedge clk) disable iff (!rst_n)
    (rise && !scr_s && mode_s[1]) |=> data_out[DATA_W-1] == !$past(pipe[LATENCY-1][DATA_W-1]);
  endproperty
  a_twos: assert property (p_twos) else $error("msb not inverted");
  property p_of;
    @(posedge clk) disable iff (!rst_n)
    rise |=> overflow_flag == $past(pipe[LATENCY-1][DATA_W]);
  endproperty
  a_of: assert property (p_of) else $error("overflow flag wrong");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
    !rise |=> $stable(data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved between strobes");
  property p_mode;
    @(posedge clk) disable iff (!rst_n)
    stabilizer_on == $past(mode_s == 2'h1 || mode_s == 2'h2);
  endproperty
  a_mode: assert property (p_mode) else $error("stabilizer decode wrong");
  c_scramble: cover property (@(posedge clk) disable iff (!rst_n) rise && scr_s);
  c_locked: cover property (@(posedge clk) disable iff (!rst_n) lock_st == AOF_S_LOCKED);
  c_twos: cover property (@(posedge clk) disable iff (!rst_n) rise && fmt == AOF_FMT_TWOS);
endmodule // aof_formatter

/* File: test/aof_capture_model.sv */
`timescale 1ns/1ps
// capture side: latches on the true clock rise and undoes scrambling
module aof_capture_model #(
  parameter int DATA_W = 14
) (
  input wire logic sample_clock_out_true,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic overflow_flag,
  input wire logic scramble_enable,
  input wire logic output_valid,
  output logic [DATA_W-1:0] cap_word,
  output logic cap_over,
  output logic cap_valid
);
  // true clock rises mid-period, so the word has long settled
  always_ff @(posedge sample_clock_out_true) begin
    cap_word <= scramble_enable ? data_out ^ {{(DATA_W-1){data_out[0]}}, 1'b0} : data_out;
    cap_over <= overflow_flag;
    cap_valid <= output_valid;
  end
endmodule // aof_capture_model

/* File: test/adc_output_formatter_tb_top.sv */
`timescale 1ns/1ps
`include "aof_regs.svh"
module adc_output_formatter_tb_top;
  import aof_pkg::*;
  localparam int W = `AOF_DATA_W;
  // short relock so the stop scenario stays brief
  localparam int RELOCK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic strobe = 1'b0;
  logic run = 1'b0;
  logic [2:0] scnt = 3'h0;
  logic [W-1:0] raw = 14'h1235;
  logic ovr = 1'b0;
  logic [1:0] mode = 2'h0;
  logic scr = 1'b0;
  logic rng = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata;
  logic [31:0] q;
  logic [W-1:0] dout;
  logic [W-1:0] cword;
  logic oflag, ck_t, ck_i, gain, stab, valid, irq, cap_of, cvalid;
  int err_count = 0;
  int n_compared = 0;

  always #5 clk = ~clk;
  // 160 ns strobe, 50% duty, frozen while run is low
  always @(posedge clk) begin
    if (run) begin
      scnt <= scnt + 3'h1;
      if (scnt == 3'h7) strobe <= ~strobe;
    end
  end

  aof_formatter #(.RELOCK(RELOCK)) dut (.clk(clk), .rst_n(rst_n), .sample_strobe_in(strobe),
    .raw_result(raw), .raw_over_range(ovr), .format_mode(mode), .scramble_enable(scr),
    .input_range_select(rng), .reg_addr(addr), .reg_wdata(wdata), .reg_write(wr_s),
    .reg_read(rd_s), .reg_rdata(rdata), .data_out(dout), .overflow_flag(oflag),
    .sample_clock_out_true(ck_t), .sample_clock_out_inverted(ck_i), .gain_narrow(gain),
    .stabilizer_on(stab), .output_valid(valid), .irq(irq));
  aof_capture_model #(.DATA_W(W)) cap (.sample_clock_out_true(ck_t), .data_out(dout),
    .overflow_flag(oflag), .scramble_enable(scr), .output_valid(valid),
    .cap_word(cword), .cap_over(cap_of), .cap_valid(cvalid));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    if (err_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 q = rdata;
  endtask
  // past the pipeline plus sync delay, outputs settled
  task settle(input int n);
    repeat (n) @(posedge strobe);
    repeat (6) @(posedge clk);
    #1;
  endtask

  // every format code, scrambling off and on, range select both ways
  task t_formats;
    logic [W-1:0] e;
    logic [W-1:0] s;
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        @(posedge clk);
        mode <= m[1:0];
        scr <= k[0];
        rng <= m[0];
        settle(7);
        e = m[1] ? raw ^ 14'h2000 : raw;
        s = k[0] ? e ^ {{(W-1){e[0]}}, 1'b0} : e;
        chk(stab, (m == 1 || m == 2));
        chk(dout, s);
        chk(dout[0], raw[0]);
        chk(cword, e);
        chk(ck_i ^ ck_t, 1'b1);
        chk(gain, m[0]);
        rd(8'h08);
        chk(q[3:0], {m[0], (m == 1 || m == 2), m[1:0]});
      end
    end
  endtask

  // overflow raises sticky status, masked then unmasked, then cleared
  task t_overflow;
    wr(8'h04, 32'h0);
    // raise the flag just after a detected rise, so the next rise samples it
    @(posedge strobe);
    repeat (4) @(posedge clk);
    ovr <= 1'b1;
    repeat (`AOF_LATENCY) @(posedge strobe);
    repeat (6) @(posedge clk);
    #1 chk(oflag, 1'b0);
    settle(1);
    chk(oflag, 1'b1);
    chk(irq, 1'b0);
    // capture side latches only at the next true clock rise
    @(posedge ck_t);
    #1 chk(cap_of, 1'b1);
    rd(8'h00);
    chk(q[0], 1'b1);
    wr(8'h04, 32'h1);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    @(posedge clk);
    ovr <= 1'b0;
    settle(7);
    chk(oflag, 1'b0);
    wr(8'h00, 32'h3);
    rd(8'h00);
    chk(q[0], 1'b0);
    chk(irq, 1'b0);
    rd(8'h10);
    chk(q, 32'h0);
  endtask

  // stopped strobe loses lock; first rise restarts, then RELOCK more rises
  task t_relock;
    @(posedge clk);
    mode <= 2'h1;
    settle(8);
    chk(valid, 1'b1);
    @(posedge clk);
    run <= 1'b0;
    repeat (100) @(posedge clk);
    #1 chk(valid, 1'b0);
    rd(8'h00);
    chk(q[1], 1'b1);
    @(posedge clk);
    run <= 1'b1;
    // the first true clock rise after restart follows the second rise
    repeat (3) @(posedge strobe);
    #1 chk(cvalid | valid, 1'b0);
    repeat (RELOCK - 3) @(posedge strobe);
    repeat (6) @(posedge clk);
    #1 chk(valid, 1'b0);
    @(posedge strobe);
    repeat (6) @(posedge clk);
    #1 chk(valid, 1'b1);
    chk(stab, 1'b1);
  endtask

  initial begin
    #200us;
    err_count++;
    conclude();
  end

  initial begin
    repeat (4) @(posedge clk);
    #1 chk({dout, oflag, ck_t, ck_i, valid, irq}, {14'h0, 5'h04});
    @(posedge clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    t_formats();
    t_overflow();
    t_relock();
    conclude();
  end
endmodule // adc_output_formatter_tb_top
